// file: rtl/tsl_pkg.sv
// Constants and types of the touch sensor host link.
// Assumes a 50 MHz system clock; all timing counts except STRAP_SETTLE derive from it.
package tsl_pkg;

	// ****************************************
	// Clock and timing
	// ****************************************
	localparam int CLK_HZ        = 50_000_000;
	localparam int CLK_PER_US    = CLK_HZ / 1_000_000;
	localparam int LAT_KEY1_MS   = 10;
	localparam int LAT_KEY8_MS   = 40;
	localparam int LAT_KEY64_MS  = 300;
	localparam int LAT_OTHER_US  = 300;
	localparam int GAP_MIN_US    = 15;
	localparam int SCK_MAX_KHZ   = 1500;
	localparam int LAT_KEY1_CYC  = LAT_KEY1_MS * 1000 * CLK_PER_US;
	localparam int LAT_KEY8_CYC  = LAT_KEY8_MS * 1000 * CLK_PER_US;
	localparam int LAT_KEY64_CYC = LAT_KEY64_MS * 1000 * CLK_PER_US;
	localparam int LAT_OTHER_CYC = LAT_OTHER_US * CLK_PER_US;
	localparam int GAP_MIN_CYC   = GAP_MIN_US * CLK_PER_US;
	// Least half period, rounded up so the link never exceeds its top rate
	localparam int SCK_HALF_CYC  = (CLK_HZ + 2 * SCK_MAX_KHZ * 1000 - 1) / (2 * SCK_MAX_KHZ * 1000);

	// ****************************************
	// Widths and reset values
	// ****************************************
	localparam int TMR_W         = 24;
	localparam int BYTE_W        = 8;
	localparam int WORD_W        = BYTE_W + 1;
	localparam int FIFO_DEPTH    = 8;
	localparam logic [2:0] LAST_BIT = 3'h7;
	localparam logic [TMR_W-1:0] STRAP_SETTLE = 24'h000003;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [2:0] {
		ST_INIT     = 3'h0,
		ST_IDLE     = 3'h1,
		ST_WAIT     = 3'h2,
		ST_SO_READY = 3'h3,
		ST_SO_DONE  = 3'h4,
		ST_MS_SEL   = 3'h5,
		ST_MS_SHIFT = 3'h6,
		ST_MS_END   = 3'h7
	} tsl_state_t;

	typedef enum logic [1:0] {
		LAT_OTHER = 2'h0,
		LAT_KEY1  = 2'h1,
		LAT_KEY8  = 2'h2,
		LAT_KEY64 = 2'h3
	} tsl_lat_t;

endpackage

// file: rtl/tsl_stream_if.sv
// Valid/ready word stream between the link and its reply buffer.
// Assumes both ends share one clock.
`timescale 1ns/10ps
`default_nettype none
interface tsl_stream_if #(parameter int W = 9) ();
	logic         valid;
	logic         ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// file: rtl/tsl_fifo.sv
// Synchronous reply buffer with valid/ready on both sides.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
module tsl_fifo #(
	parameter int W = 9,
	parameter int D = 8
) (
	// Clock and reset
	input  wire logic   sys_clk_i,
	input  wire logic   reset_n_i,
	// Streams
	tsl_stream_if.snk   wr_s,
	tsl_stream_if.src   rd_s,
	// Fill level
	output logic        afull_o
);
	localparam int AW = $clog2(D);

	logic [W-1:0] mem_q [D];
	logic [AW-1:0] wp_q;
	logic [AW-1:0] rp_q;
	logic [AW:0]   cnt_q;

	wire push = wr_s.valid & wr_s.ready;
	wire pop  = rd_s.valid & rd_s.ready;

	assign wr_s.ready = (cnt_q != (AW+1)'(D));
	assign rd_s.valid = (cnt_q != '0);
	assign rd_s.data  = mem_q[rp_q];
	assign afull_o    = (cnt_q >= (AW+1)'(D - 1));

	always_ff @(posedge sys_clk_i)
	begin
		if (push)
			mem_q[wp_q] <= wr_s.data;
	end

	always_ff @(posedge sys_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			wp_q  <= '0;
			rp_q  <= '0;
			cnt_q <= '0;
		end
		else
		begin
			wp_q  <= push ? AW'(wp_q + 1'b1) : wp_q;
			rp_q  <= pop ? AW'(rp_q + 1'b1) : rp_q;
			cnt_q <= (AW+1)'(cnt_q + push - pop);
		end
	end

	a_fifo_no_over: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
		cnt_q == (AW+1)'(D) |-> !push) else $error("buffer written while full");
endmodule
`default_nettype wire

// file: rtl/tsl_link.sv
// Host-facing serial link of a touch-key sensor, sensor side.
// Assumes all link pins are asynchronous to sys_clk_i and that a key
// processing core feeds replies and consumes command bytes.
`timescale 1ns/10ps
`default_nettype none

module tsl_link #(
	parameter int LAT_KEY1_CYC  = tsl_pkg::LAT_KEY1_CYC,
	parameter int LAT_KEY8_CYC  = tsl_pkg::LAT_KEY8_CYC,
	parameter int LAT_KEY64_CYC = tsl_pkg::LAT_KEY64_CYC,
	parameter int LAT_OTHER_CYC = tsl_pkg::LAT_OTHER_CYC,
	parameter int GAP_MIN_CYC   = tsl_pkg::GAP_MIN_CYC,
	parameter int FIFO_DEPTH    = tsl_pkg::FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic       sys_clk_i,
	input  wire logic       reset_n_i,
	// Link pins
	input  wire logic       link_mode_strap_i,
	input  wire logic       sck_i,
	output logic            sck_o,
	output logic            sck_oe_o,
	input  wire logic       ss_n_i,
	output logic            ss_n_o,
	output logic            ss_n_oe_o,
	input  wire logic       mosi_i,
	output logic            mosi_o,
	output logic            mosi_oe_o,
	output logic            miso_o,
	output logic            miso_oe_o,
	output logic            drdy_n_o,
	// Command bytes to the core
	output logic            cmd_valid_o,
	output logic [7:0]      cmd_data_o,
	input  wire logic [1:0] lat_class_i,
	// Replies from the core
	input  wire logic       reply_valid_i,
	input  wire logic [7:0] reply_data_i,
	input  wire logic       reply_last_i,
	output logic            reply_ready_o,
	input  wire logic       echo_req_i,
	// Status
	output logic            mode_ms_o
);
	localparam int TW = tsl_pkg::TMR_W;
	localparam logic [TW-1:0] HALF = TW'(tsl_pkg::SCK_HALF_CYC);
	localparam logic [TW-1:0] GAP  = TW'(GAP_MIN_CYC);

	// ****************************************
	// Pin synchronisers
	// ****************************************
	// Reset to the pins' idle levels so no false clock edge follows reset
	localparam logic [3:0] PIN_IDLE = 4'hE;
	logic [3:0] meta_q;
	logic [3:0] sync_q;
	logic       sck_prev_q;

	always_ff @(posedge sys_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			meta_q     <= PIN_IDLE;
			sync_q     <= PIN_IDLE;
			sck_prev_q <= 1'b0;
		end
		else
		begin
			meta_q     <= {link_mode_strap_i, mosi_i, ss_n_i, sck_i};
			sync_q     <= meta_q;
			sck_prev_q <= sync_q[0];
		end
	end

	wire sck_s    = sync_q[0];
	wire ss_s     = sync_q[1];
	wire mosi_s   = sync_q[2];
	wire strap_s  = sync_q[3];
	wire sck_rise = sck_s & ~sck_prev_q;
	wire sck_fall = ~sck_s & sck_prev_q;

	// ****************************************
	// Reply buffer
	// ****************************************
	tsl_stream_if #(.W(tsl_pkg::WORD_W)) wr_s ();
	tsl_stream_if #(.W(tsl_pkg::WORD_W)) rd_s ();
	logic fifo_afull;

	tsl_fifo #(.W(tsl_pkg::WORD_W), .D(FIFO_DEPTH)) u_fifo (
		.sys_clk_i (sys_clk_i),
		.reset_n_i (reset_n_i),
		.wr_s      (wr_s),
		.rd_s      (rd_s),
		.afull_o   (fifo_afull)
	);

	// ****************************************
	// State
	// ****************************************
	tsl_pkg::tsl_state_t state_q, state_d;
	logic          mode_q, mode_d;
	logic [7:0]    rx_q, rx_d;
	logic [2:0]    rxcnt_q, rxcnt_d;
	logic [7:0]    cmd_q, cmd_d;
	logic          pend_q, pend_d;
	logic [TW-1:0] tmr_q, tmr_d;
	logic [7:0]    tx_q, tx_d;
	logic          last_q, last_d;
	logic [2:0]    bit_q, bit_d;
	logic          sck_q, sck_d, sck_oe_q, sck_oe_d;
	logic          ss_q, ss_d, ss_oe_q, ss_oe_d;
	logic          mosi_q, mosi_d, mosi_oe_q, mosi_oe_d;
	logic          miso_q, miso_d, miso_oe_q, miso_oe_d;
	logic          drdy_q, drdy_d, cval_q, rrdy_q;

	// Receive only while no reply is being handed out; dummy bytes drop
	wire rx_en     = (state_q == tsl_pkg::ST_IDLE || state_q == tsl_pkg::ST_WAIT) & ~ss_s;
	wire rx_bit    = rx_en & sck_rise;
	wire byte_done = rx_bit & (rxcnt_q == tsl_pkg::LAST_BIT);
	wire tmr_zero  = (tmr_q == '0);
	wire pop       = (state_q == tsl_pkg::ST_WAIT) & tmr_zero & rd_s.valid;
	wire [TW-1:0] lat_sel =
		(lat_class_i == tsl_pkg::LAT_KEY1)  ? TW'(LAT_KEY1_CYC)  :
		(lat_class_i == tsl_pkg::LAT_KEY8)  ? TW'(LAT_KEY8_CYC)  :
		(lat_class_i == tsl_pkg::LAT_KEY64) ? TW'(LAT_KEY64_CYC) : TW'(LAT_OTHER_CYC);

	// Replies are taken only while a command is outstanding; echo wins
	// Core bytes need the registered ready, else a refused byte is taken twice
	assign wr_s.valid = pend_q & (echo_req_i | (reply_valid_i & rrdy_q));
	assign wr_s.data  = echo_req_i ? {1'b1, cmd_q} : {reply_last_i, reply_data_i};
	assign rd_s.ready = pop;

	always_comb
	begin
		state_d = state_q;   mode_d = mode_q;   cmd_d = cmd_q;   pend_d = pend_q;
		tmr_d = tmr_zero ? tmr_q : TW'(tmr_q - 1'b1);
		tx_d = tx_q;         last_d = last_q;   bit_d = bit_q;
		sck_d = sck_q;       sck_oe_d = sck_oe_q;
		ss_d = ss_q;         ss_oe_d = ss_oe_q;
		mosi_d = mosi_q;     mosi_oe_d = mosi_oe_q;
		miso_d = miso_q;     miso_oe_d = 1'b0;  drdy_d = drdy_q;
		rx_d    = rx_bit ? {rx_q[6:0], mosi_s} : rx_q;
		rxcnt_d = ss_s ? 3'h0 : (rx_bit ? 3'(rxcnt_q + 1'b1) : rxcnt_q);
		if (byte_done)
		begin
			cmd_d  = {rx_q[6:0], mosi_s};
			pend_d = 1'b1;
			tmr_d  = lat_sel;
			if (state_q == tsl_pkg::ST_IDLE)
				state_d = tsl_pkg::ST_WAIT;
		end
		unique case (state_q)
			tsl_pkg::ST_INIT:
				if (tmr_zero)
				begin
					mode_d  = ~strap_s;
					state_d = tsl_pkg::ST_IDLE;
				end
			tsl_pkg::ST_IDLE: ;
			tsl_pkg::ST_WAIT:
				if (pop)
				begin
					tx_d   = rd_s.data[7:0];
					last_d = rd_s.data[8];
					bit_d  = 3'h0;
					if (mode_q)
					begin
						state_d = tsl_pkg::ST_MS_SEL;
						tmr_d = HALF;
						sck_d = 1'b0;  sck_oe_d = 1'b1;
						ss_d = 1'b0;   ss_oe_d = 1'b1;
						mosi_d = rd_s.data[7];  mosi_oe_d = 1'b1;
					end
					else
					begin
						state_d = tsl_pkg::ST_SO_READY;
						miso_d  = rd_s.data[7];
						drdy_d  = 1'b0;
					end
				end
			tsl_pkg::ST_SO_READY:
			begin
				miso_oe_d = ~ss_s;
				if (~ss_s & sck_fall)
				begin
					tx_d   = {tx_q[6:0], 1'b0};
					miso_d = tx_q[6];
				end
				if (~ss_s & sck_rise)
				begin
					bit_d = 3'(bit_q + 1'b1);
					if (bit_q == tsl_pkg::LAST_BIT)
					begin
						drdy_d  = 1'b1;
						state_d = tsl_pkg::ST_SO_DONE;
					end
				end
			end
			tsl_pkg::ST_SO_DONE:
			begin
				miso_oe_d = ~ss_s;
				// Next byte waits for the host to close the frame
				if (ss_s)
				begin
					miso_oe_d = 1'b0;
					state_d = last_q ? tsl_pkg::ST_IDLE : tsl_pkg::ST_WAIT;
					pend_d  = ~last_q;
					tmr_d   = GAP;
				end
			end
			tsl_pkg::ST_MS_SEL:
				if (tmr_zero)
				begin
					state_d = tsl_pkg::ST_MS_SHIFT;
					sck_d = 1'b1;
					tmr_d = HALF;
				end
			tsl_pkg::ST_MS_SHIFT:
				if (tmr_zero)
				begin
					tmr_d = HALF;
					sck_d = ~sck_q;
					if (sck_q)
					begin
						bit_d = 3'(bit_q + 1'b1);
						if (bit_q == tsl_pkg::LAST_BIT)
							state_d = tsl_pkg::ST_MS_END;
						else
						begin
							tx_d   = {tx_q[6:0], 1'b0};
							mosi_d = tx_q[6];
						end
					end
				end
			tsl_pkg::ST_MS_END:
				if (tmr_zero)
				begin
					if (!ss_q)
					begin
						// Drive select high briefly before floating it
						ss_d  = 1'b1;
						tmr_d = HALF;
					end
					else
					begin
						sck_oe_d = 1'b0;  ss_oe_d = 1'b0;  mosi_oe_d = 1'b0;
						state_d = last_q ? tsl_pkg::ST_IDLE : tsl_pkg::ST_WAIT;
						pend_d  = ~last_q;
						tmr_d   = GAP;
					end
				end
		endcase
	end

	always_ff @(posedge sys_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			state_q <= tsl_pkg::ST_INIT;  mode_q <= 1'b0;
			rx_q <= 8'h00;  rxcnt_q <= 3'h0;  cmd_q <= 8'h00;  pend_q <= 1'b0;
			tmr_q <= tsl_pkg::STRAP_SETTLE;  tx_q <= 8'h00;  last_q <= 1'b0;
			bit_q <= 3'h0;  sck_q <= 1'b0;  sck_oe_q <= 1'b0;
			ss_q <= 1'b1;   ss_oe_q <= 1'b0;  mosi_q <= 1'b0;  mosi_oe_q <= 1'b0;
			miso_q <= 1'b0; miso_oe_q <= 1'b0;  drdy_q <= 1'b1;
			cval_q <= 1'b0; cmd_data_o <= 8'h00;  rrdy_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;  mode_q <= mode_d;
			rx_q <= rx_d;  rxcnt_q <= rxcnt_d;  cmd_q <= cmd_d;  pend_q <= pend_d;
			tmr_q <= tmr_d;  tx_q <= tx_d;  last_q <= last_d;
			bit_q <= bit_d;  sck_q <= sck_d;  sck_oe_q <= sck_oe_d;
			ss_q <= ss_d;    ss_oe_q <= ss_oe_d;  mosi_q <= mosi_d;  mosi_oe_q <= mosi_oe_d;
			miso_q <= miso_d;  miso_oe_q <= miso_oe_d;  drdy_q <= drdy_d;
			cval_q <= byte_done;
			cmd_data_o <= byte_done ? cmd_d : cmd_data_o;
			// One word of margin covers the registered ready
			rrdy_q <= pend_d & ~fifo_afull & ~echo_req_i;
		end
	end

	assign sck_o = sck_q;          assign sck_oe_o  = sck_oe_q;
	assign ss_n_o = ss_q;          assign ss_n_oe_o = ss_oe_q;
	assign mosi_o = mosi_q;        assign mosi_oe_o = mosi_oe_q;
	assign miso_o = miso_q;        assign miso_oe_o = miso_oe_q;
	assign drdy_n_o = drdy_q;      assign cmd_valid_o = cval_q;
	assign reply_ready_o = rrdy_q; assign mode_ms_o = mode_q;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!reset_n_i);

	a_no_spont_tx: assert property ($fell(drdy_n_o) || $rose(ss_oe_q) |-> $past(pend_q))
		else $error("reply started without a command");
	a_mode_frozen: assert property ($past(state_q) != tsl_pkg::ST_INIT |-> $stable(mode_q))
		else $error("link mode changed after start");
	a_rx_on_rise: assert property (cmd_valid_o |-> $past(sck_rise) && !$past(ss_s))
		else $error("command byte not completed on rising clock");
	a_drdy_ms_idle: assert property (mode_q |-> drdy_n_o)
		else $error("ready asserted in master/slave mode");
	a_lat_loaded: assert property (cmd_valid_o |-> tmr_q == $past(lat_sel) && pend_q)
		else $error("reply delay not loaded from command class");
	a_drdy_release: assert property (state_q == tsl_pkg::ST_SO_DONE |-> drdy_n_o)
		else $error("ready low after reply byte");
	a_ms_data_edge: assert property (mosi_oe_o && $past(mosi_oe_o) && $changed(mosi_o)
		|-> $fell(sck_o))
		else $error("master data changed off falling clock");
	a_ms_framed: assert property (sck_oe_o && sck_o |-> ss_n_oe_o && !ss_n_o)
		else $error("master clock outside select frame");
	a_gap_kept: assert property (state_q == tsl_pkg::ST_WAIT && !$stable(state_q) && pend_q
		|-> tmr_q == GAP || $past(byte_done))
		else $error("byte gap not loaded");
	a_echo_word: assert property (echo_req_i && pend_q |-> wr_s.valid && wr_s.data[8]
		&& wr_s.data[7:0] == cmd_q)
		else $error("echo not the command code");
	a_quiet_deselect: assert property (ss_s && !mode_q |=> !miso_oe_o)
		else $error("data driven while deselected");

	c_cmd_rx:  cover property (cmd_valid_o);
	c_so_byte: cover property (state_q == tsl_pkg::ST_SO_DONE ##1 state_q == tsl_pkg::ST_IDLE);
	c_ms_byte: cover property ($fell(ss_oe_q) && mode_q);
	c_echo:    cover property (echo_req_i && wr_s.valid && wr_s.ready);
endmodule
`default_nettype wire

// file: verif/tsl_host_model.sv
// Host controller model on the far side of the sensor link.
// Assumes a 50 MHz bench clock; one link half period is 4 cycles.
`timescale 1ns/10ps
`default_nettype none
module tsl_host_model (
	// Clock
	input  wire logic sys_clk_i,
	// Sensor drivers
	input  wire logic sck_o,
	input  wire logic sck_oe_o,
	input  wire logic ss_n_o,
	input  wire logic ss_n_oe_o,
	input  wire logic mosi_o,
	input  wire logic mosi_oe_o,
	input  wire logic miso_o,
	input  wire logic drdy_n_o,
	// Resolved pins
	output logic      sck_pin_o,
	output logic      ss_pin_o,
	output logic      mosi_pin_o
);
	logic h_drv = 1'b1;
	logic h_sck = 1'b0;
	logic h_ss_n = 1'b1;
	logic h_mosi = 1'b0;

	// Pulldown on clock, pullup on select, data wanders when released
	assign sck_pin_o  = sck_oe_o ? sck_o : (h_drv & h_sck);
	assign ss_pin_o   = ss_n_oe_o ? ss_n_o : (~h_drv | h_ss_n);
	assign mosi_pin_o = mosi_oe_o ? mosi_o : h_mosi;

	always @(posedge sys_clk_i)
		if (!h_drv)
			h_mosi <= ~h_mosi;

	// 6.25 MHz link, above the 1.5 MHz top rate
	task automatic half();
		repeat (4) @(posedge sys_clk_i);
	endtask

	task automatic send_byte(input logic [7:0] b, input logic sel);
		@(posedge sys_clk_i);
		h_drv  <= 1'b1;
		h_ss_n <= ~sel;
		for (int i = 7; i >= 0; i--)
		begin
			half();
			h_sck  <= 1'b0;
			h_mosi <= b[i];
			half();
			h_sck <= 1'b1;
		end
		half();
		h_sck <= 1'b0;
		half();
		h_ss_n <= 1'b1;
		h_mosi <= ~b[0];
		half();
	endtask

	task automatic fetch_byte(output logic [7:0] b, output logic ok);
		int n;
		b = 8'h00;
		n = 0;
		while (drdy_n_o !== 1'b0 && n < 3000)
		begin
			@(negedge sys_clk_i);
			n++;
		end
		@(posedge sys_clk_i);
		h_ss_n <= 1'b0;
		for (int i = 7; i >= 0; i--)
		begin
			h_mosi <= 1'b0;
			half();
			h_sck <= 1'b1;
			half();
			b[i] = miso_o;
			h_sck <= 1'b0;
		end
		n = 0;
		while (drdy_n_o !== 1'b1 && n < 40)
		begin
			@(negedge sys_clk_i);
			n++;
		end
		ok = (drdy_n_o === 1'b1);
		half();
		h_ss_n <= 1'b1;
		half();
	endtask

	task automatic ms_recv(output logic [7:0] b, output logic ok);
		int   n;
		logic p;
		b = 8'h00;
		h_drv <= 1'b0;
		n = 0;
		while (ss_pin_o !== 1'b0 && n < 600)
		begin
			@(negedge sys_clk_i);
			n++;
		end
		for (int i = 7; i >= 0; i--)
		begin
			n = 0;
			do
			begin
				p = sck_pin_o;
				@(negedge sys_clk_i);
				n++;
			end
			while (!(sck_pin_o === 1'b1 && p === 1'b0) && n < 60);
			b[i] = mosi_pin_o;
		end
		n = 0;
		while (ss_pin_o !== 1'b1 && n < 60)
		begin
			@(negedge sys_clk_i);
			n++;
		end
		ok = (n < 60);
	endtask
endmodule
`default_nettype wire

// file: verif/tsl_link_tb_top.sv
// Self-checking bench of the sensor-side link in both strap modes.
// Assumes the host model resolves every shared pin.
`timescale 1ns/10ps
`default_nettype none
module tsl_link_tb_top;
	localparam int LATS [4] = '{100, 200, 300, 400};
	localparam int GAP_MIN  = 750;
	localparam int IDLE_CYC = 50_000;

	logic       sys_clk;
	logic       reset_n;
	logic       strap;
	logic [1:0] lat_class;
	logic       rv;
	logic [7:0] rd;
	logic       rl;
	logic       echo;
	wire logic  sck_pin, ss_pin, mosi_pin;
	wire logic  sck_o, sck_oe, ss_n_o, ss_n_oe, mosi_o, mosi_oe, miso_o, miso_oe;
	wire logic  drdy_n, cmd_valid, reply_ready, mode_ms;
	wire logic [7:0] cmd_data;
	int         errors = 0;
	int         n_checks = 0;
	int         n_cmd = 0;
	int         n_miso = 0;

	tsl_link #(.LAT_OTHER_CYC(LATS[0]), .LAT_KEY1_CYC(LATS[1]), .LAT_KEY8_CYC(LATS[2]),
		.LAT_KEY64_CYC(LATS[3]), .GAP_MIN_CYC(GAP_MIN), .FIFO_DEPTH(8)) dut_u (
		.sys_clk_i(sys_clk), .reset_n_i(reset_n), .link_mode_strap_i(strap),
		.sck_i(sck_pin), .sck_o(sck_o), .sck_oe_o(sck_oe), .ss_n_i(ss_pin),
		.ss_n_o(ss_n_o), .ss_n_oe_o(ss_n_oe), .mosi_i(mosi_pin), .mosi_o(mosi_o),
		.mosi_oe_o(mosi_oe), .miso_o(miso_o), .miso_oe_o(miso_oe), .drdy_n_o(drdy_n),
		.cmd_valid_o(cmd_valid), .cmd_data_o(cmd_data), .lat_class_i(lat_class),
		.reply_valid_i(rv), .reply_data_i(rd), .reply_last_i(rl),
		.reply_ready_o(reply_ready), .echo_req_i(echo), .mode_ms_o(mode_ms));

	tsl_host_model host_u (.sys_clk_i(sys_clk), .sck_o(sck_o), .sck_oe_o(sck_oe),
		.ss_n_o(ss_n_o), .ss_n_oe_o(ss_n_oe), .mosi_o(mosi_o), .mosi_oe_o(mosi_oe),
		.miso_o(miso_o), .drdy_n_o(drdy_n), .sck_pin_o(sck_pin), .ss_pin_o(ss_pin),
		.mosi_pin_o(mosi_pin));

	initial
	begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	always @(negedge sys_clk)
	begin
		n_cmd  += (cmd_valid === 1'b1);
		n_miso += (miso_oe === 1'b1 && mode_ms === 1'b1);
	end

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("BAD %s expected %0h seen %0h", what, exp, got);
		end
	endtask

	task automatic do_reset(input logic s);
		reset_n <= 1'b0;
		strap   <= s;
		repeat (2) @(posedge sys_clk);
		reset_n <= 1'b1;
		repeat (10) @(posedge sys_clk);
	endtask

	task automatic pulse_echo();
		@(posedge sys_clk);
		echo <= 1'b1;
		@(posedge sys_clk);
		echo <= 1'b0;
	endtask

	task automatic t_idle();
		int lows;
		int c0;
		lows = 0;
		do_reset(1'b1);
		chk("mode", 0, mode_ms);
		chk("ready idle", 1, drdy_n);
		pulse_echo();
		c0 = n_cmd;
		host_u.send_byte(8'hA5, 1'b0);
		repeat (300)
		begin
			@(negedge sys_clk);
			lows += (drdy_n !== 1'b1);
		end
		chk("unsolicited ready", 0, lows);
		chk("deselected bytes", c0, n_cmd);
		$display("t_idle done");
	endtask

	task automatic t_echo(input int cls);
		logic [7:0] b;
		logic       ok;
		int         n;
		int         c0;
		c0 = n_cmd;
		lat_class <= 2'(cls);
		host_u.send_byte(8'h60 | 8'(cls), 1'b1);
		chk("cmd count", c0 + 1, n_cmd);
		chk("cmd byte", 8'h60 | 8'(cls), cmd_data);
		chk("ready after cmd", 1, drdy_n);
		pulse_echo();
		n = 0;
		while (drdy_n !== 1'b0 && n < 1000)
		begin
			@(negedge sys_clk);
			n++;
		end
		chk("latency", 1, n + 30 >= LATS[cls] && n <= LATS[cls] + 30);
		host_u.fetch_byte(b, ok);
		chk("echo", 8'h60 | 8'(cls), b);
		chk("ready released", 1, ok);
		repeat (50) @(posedge sys_clk);
		$display("t_echo class %0d done", cls);
	endtask

	task automatic t_multi();
		logic [7:0] b;
		logic       ok;
		logic       full_seen;
		int         n;
		full_seen = 1'b0;
		lat_class <= 2'h0;
		host_u.send_byte(8'h80, 1'b1);
		repeat (2500) @(posedge sys_clk);
		host_u.send_byte(8'h05, 1'b1);
		fork
			begin
				// One byte more than the buffer holds, so ready must fall
				for (int i = 0; i < 9; i++)
				begin
					rv <= 1'b1;
					rd <= 8'hC0 | 8'(i);
					rl <= (i == 8);
					do
					begin
						@(negedge sys_clk);
						full_seen |= (reply_ready !== 1'b1);
					end
					while (reply_ready !== 1'b1);
					@(posedge sys_clk);
				end
				rv <= 1'b0;
			end
			for (int j = 0; j < 9; j++)
			begin
				host_u.fetch_byte(b, ok);
				chk("reply byte", 8'hC0 | 8'(j), b);
				chk("ready released", 1, ok);
				n = 0;
				while (j < 8 && drdy_n !== 1'b0 && n < 3000)
				begin
					@(negedge sys_clk);
					n++;
				end
				if (j < 8)
					chk("byte gap", 1, n + 10 >= GAP_MIN && n <= GAP_MIN + 200);
			end
		join
		chk("buffer refused", 1, full_seen);
		$display("t_multi done");
	endtask

	task automatic t_ms();
		logic [7:0] b;
		logic       ok;
		int         c0;
		do_reset(1'b0);
		chk("mode", 1, mode_ms);
		lat_class <= 2'h0;
		host_u.send_byte(8'h67, 1'b1);
		fork
			host_u.ms_recv(b, ok);
			pulse_echo();
		join
		chk("master byte", 8'h67, b);
		chk("select framing", 1, ok);
		repeat (40) @(negedge sys_clk);
		chk("drivers off", 0, {sck_oe, ss_n_oe, mosi_oe, miso_oe});
		chk("data out unused", 0, n_miso);
		c0 = n_cmd;
		repeat (IDLE_CYC) @(posedge sys_clk);
		host_u.send_byte(8'h68, 1'b1);
		chk("cmd after idle", c0 + 1, n_cmd);
		$display("t_ms done");
	endtask

	initial
	begin
		reset_n   = 1'b0;
		strap     = 1'b1;
		lat_class = 2'h0;
		rv        = 1'b0;
		rd        = 8'h00;
		rl        = 1'b0;
		echo      = 1'b0;
		t_idle();
		for (int c = 0; c < 4; c++)
			t_echo(c);
		t_multi();
		t_ms();
		tally_and_finish();
	end

	initial
	begin
		#(90_000 * 20);
		errors++;
		$display("watchdog expired");
		tally_and_finish();
	end
endmodule
`default_nettype wire
